// ---- rtl/gts_top.sv ----
// general timer set: one primary 16-bit timer and two cascadable pairs
// assumes an APB master on clk and pins that need synchronising
//
// Overview of operation
// - primary timer is 16-bit: timer, synchronous or asynchronous counter
// - primary flags on period match or gate falling edge when gated
// - run bit 15 starts the counter, clearing it stops it
// - idle-stop bit 13 halts the timer in idle mode
// - gate bit 6 counts internal clocks while gate high; ignored external
// - prescale field divides by 1, 8, 64 or 256
// - sync bit 2 picks synchronised or asynchronous external counting
// - clock-source bit 1 picks external pin rising edges or internal clock
// - unimplemented primary control bits read as zero
// - each pair is one 32-bit timer or two 16-bit timers
// - cascaded pair is 32-bit timer or synchronous counter, never async
// - paired 16-bit timers are synchronous only, with gate and prescale
// - cascade bit 3 of lower control joins the pair
// - cascaded pair ignores upper control, uses lower control only
// - cascaded pair uses lower timer's clock and gate pin
// - cascaded match raises the upper timer's flag
// - cascaded period is upper period high word, lower low word
// - cascaded count is upper count high word, lower low word
// - only first pair's upper timer drives the conversion trigger
// - timers may keep running in idle per idle-stop; in sleep only the async primary counter runs
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "gts_cfg.svh"

module gts_top (
   input  wire logic                    clk,         // 40 MHz clock
   input  wire logic                    resetn,      // async reset, active low
   input  wire gts_pkg::gts_apb_req_type apb_req,    // apb request
   output      gts_pkg::gts_apb_rsp_type apb_rsp,    // apb response
   input  wire logic [4:0]              ext_clk_pin, // clock and gate pins
   input  wire logic                    idle_mode,   // device in idle
   input  wire logic                    sleep_mode,  // device in sleep
   output      logic [4:0]              irq_flag,    // sticky timer flags
   output      logic                    adc_trig     // conversion trigger pulse
);

   // ----------------------------------------------------------------------
   // reset release
   // ----------------------------------------------------------------------
   logic [1:0] rst_sync_q;
   logic       rst_n;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rst_sync_q <= 2'b00;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [7:0] ps_term(input logic [1:0] code);
      logic [7:0] t;
      t = `GTS_PS_TERM_1;
      unique case (code)
         2'b00: t = `GTS_PS_TERM_1;
         2'b01: t = `GTS_PS_TERM_8;
         2'b10: t = `GTS_PS_TERM_64;
         2'b11: t = `GTS_PS_TERM_256;
      endcase
      return t;
   endfunction : ps_term

   function automatic logic [15:0] ctrl_mask(input int i);
      logic [15:0] m;
      m = `GTS_MASK_HIGH;
      if (i == 0) begin
         m = `GTS_MASK_PRIM;
      end else if (i == 1 || i == 3) begin
         m = `GTS_MASK_LOW;
      end
      return m;
   endfunction : ctrl_mask

   function automatic gts_pkg::gts_dec_type decode(input logic [`GTS_AW-1:0] a);
      gts_pkg::gts_dec_type d;
      d.kind = gts_pkg::K_NONE;
      d.idx  = 3'h0;
      case (a)
         `GTS_OFS_P_CTRL:  d = '{gts_pkg::K_CTRL,   3'h0};
         `GTS_OFS_P_COUNT: d = '{gts_pkg::K_COUNT,  3'h0};
         `GTS_OFS_P_PER:   d = '{gts_pkg::K_PERIOD, 3'h0};
         `GTS_OFS_A_LCTRL: d = '{gts_pkg::K_CTRL,   3'h1};
         `GTS_OFS_A_HCTRL: d = '{gts_pkg::K_CTRL,   3'h2};
         `GTS_OFS_A_LCNT:  d = '{gts_pkg::K_COUNT,  3'h1};
         `GTS_OFS_A_HCNT:  d = '{gts_pkg::K_COUNT,  3'h2};
         `GTS_OFS_A_LPER:  d = '{gts_pkg::K_PERIOD, 3'h1};
         `GTS_OFS_A_HPER:  d = '{gts_pkg::K_PERIOD, 3'h2};
         `GTS_OFS_A_HOLD:  d = '{gts_pkg::K_HOLD,   3'h0};
         `GTS_OFS_B_LCTRL: d = '{gts_pkg::K_CTRL,   3'h3};
         `GTS_OFS_B_HCTRL: d = '{gts_pkg::K_CTRL,   3'h4};
         `GTS_OFS_B_LCNT:  d = '{gts_pkg::K_COUNT,  3'h3};
         `GTS_OFS_B_HCNT:  d = '{gts_pkg::K_COUNT,  3'h4};
         `GTS_OFS_B_LPER:  d = '{gts_pkg::K_PERIOD, 3'h3};
         `GTS_OFS_B_HPER:  d = '{gts_pkg::K_PERIOD, 3'h4};
         `GTS_OFS_B_HOLD:  d = '{gts_pkg::K_HOLD,   3'h1};
         `GTS_OFS_FLAGS:   d = '{gts_pkg::K_FLAGS,  3'h0};
         default:          d = '{gts_pkg::K_NONE,   3'h0};
      endcase
      return d;
   endfunction : decode

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   gts_pkg::gts_state_type s_q;
   gts_pkg::gts_state_type s_d;

   logic [15:0]          ctl;
   logic                 ext;
   logic                 asyn;
   logic                 run;
   logic                 gated;
   logic                 src;
   logic                 tick;
   logic                 casc;
   logic                 rise;
   logic                 fall;
   logic [2:0]           fidx;
   logic [31:0]          wcnt;
   logic [31:0]          wper;
   logic [4:0]           set_flag;
   logic [4:0]           clr_flag;
   logic                 access;
   gts_pkg::gts_dec_type dec;
   int                   p;

   always_comb begin
      s_d      = s_q;
      ctl      = `GTS_CTRL_RST;
      ext      = 1'b0;
      asyn     = 1'b0;
      run      = 1'b0;
      gated    = 1'b0;
      src      = 1'b0;
      tick     = 1'b0;
      casc     = 1'b0;
      rise     = 1'b0;
      fall     = 1'b0;
      fidx     = 3'h0;
      wcnt     = 32'h0000_0000;
      wper     = 32'h0000_0000;
      set_flag = 5'h00;
      clr_flag = 5'h00;
      p        = 0;
      access   = apb_req.psel & apb_req.penable;
      dec      = decode(apb_req.paddr);

      s_d.adc_trig = 1'b0;
      s_d.pin_s1   = ext_clk_pin;
      s_d.pin_s2   = s_q.pin_s1;
      s_d.pin_prev = s_q.pin_s2;

      // ------------------------------------------------------------------
      // counting engines
      // ------------------------------------------------------------------
      for (int i = 0; i < 5; i++) begin
         if (!((i == 2 && s_q.tmr[1].ctrl[`GTS_CASC_BIT])
               || (i == 4 && s_q.tmr[3].ctrl[`GTS_CASC_BIT]))) begin
            ctl  = s_q.tmr[i].ctrl;
            casc = (i == 1 || i == 3) && ctl[`GTS_CASC_BIT];
            ext  = ctl[`GTS_CS_BIT];
            // async only on primary; pairs stay synchronous
            asyn = (i == 0) && ext && !ctl[`GTS_SYNC_BIT];
            run  = ctl[`GTS_RUN_BIT] && !(idle_mode && ctl[`GTS_IDLE_BIT])
                   && (!sleep_mode || asyn);
            gated = !ext && ctl[`GTS_GATE_BIT];
            // lower timer's own pin serves clock and gate
            rise = s_q.pin_s2[i] & ~s_q.pin_prev[i];
            fall = ~s_q.pin_s2[i] & s_q.pin_prev[i];
            src  = ext ? rise : (gated ? s_q.pin_s2[i] : 1'b1);
            // cascaded events land on the upper flag
            fidx = casc ? 3'(i + 1) : 3'(i);
            if (run && gated && fall) begin
               set_flag[fidx] = 1'b1;
            end
            tick = 1'b0;
            if (run && src) begin
               if (s_q.tmr[i].pre >= ps_term(ctl[`GTS_PS_HI:`GTS_PS_LO])) begin
                  s_d.tmr[i].pre = `GTS_PRE_RST;
                  tick           = 1'b1;
               end else begin
                  s_d.tmr[i].pre = s_q.tmr[i].pre + 8'h01;
               end
            end
            if (tick) begin
               if (casc) begin
                  wcnt = {s_q.tmr[fidx].count, s_q.tmr[i].count};
                  wper = {s_q.tmr[fidx].period, s_q.tmr[i].period};
                  // match wraps to zero and flags
                  if (wcnt == wper) begin
                     wcnt           = 32'h0000_0000;
                     set_flag[fidx] = 1'b1;
                     if (i == 1) begin
                        s_d.adc_trig = 1'b1;
                     end
                  end else begin
                     wcnt = wcnt + 32'h0000_0001;
                  end
                  s_d.tmr[fidx].count = wcnt[31:16];
                  s_d.tmr[i].count   = wcnt[15:0];
               end else begin
                  if (s_q.tmr[i].count == s_q.tmr[i].period) begin
                     s_d.tmr[i].count = `GTS_COUNT_RST;
                     set_flag[fidx]   = 1'b1;
                     if (i == 2) begin
                        s_d.adc_trig = 1'b1;
                     end
                  end else begin
                     s_d.tmr[i].count = s_q.tmr[i].count + 16'h0001;
                  end
               end
            end
         end
      end

      // ------------------------------------------------------------------
      // apb slave
      // ------------------------------------------------------------------
      if (s_q.pready) begin
         s_d.pready  = 1'b0;
         s_d.pslverr = 1'b0;
      end else if (access) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = (dec.kind == gts_pkg::K_NONE);
         s_d.prdata  = 32'h0000_0000;
         unique case (dec.kind)
            // unimplemented bits are never stored, read zero
            gts_pkg::K_CTRL:   s_d.prdata[15:0] = s_q.tmr[dec.idx].ctrl;
            gts_pkg::K_COUNT:  s_d.prdata[15:0] = s_q.tmr[dec.idx].count;
            gts_pkg::K_PERIOD: s_d.prdata[15:0] = s_q.tmr[dec.idx].period;
            gts_pkg::K_HOLD:   s_d.prdata[15:0] = s_q.hold[dec.idx[0]];
            gts_pkg::K_FLAGS:  s_d.prdata[4:0]  = s_q.flag;
            gts_pkg::K_NONE:   s_d.prdata       = 32'h0000_0000;
         endcase
         // lower word read latches upper word
         if (!apb_req.pwrite && dec.kind == gts_pkg::K_COUNT
             && (dec.idx == 3'h1 || dec.idx == 3'h3)
             && s_q.tmr[dec.idx].ctrl[`GTS_CASC_BIT]) begin
            p = (dec.idx == 3'h1) ? 0 : 1;
            s_d.hold[p] = s_q.tmr[dec.idx+3'h1].count;
         end
      end

      // write takes effect at the completing edge
      if (access && s_q.pready && apb_req.pwrite) begin
         unique case (dec.kind)
            gts_pkg::K_CTRL: begin
               s_d.tmr[dec.idx].ctrl = apb_req.pwdata[15:0] & ctrl_mask(int'(dec.idx));
            end
            gts_pkg::K_COUNT: begin
               s_d.tmr[dec.idx].count = apb_req.pwdata[15:0];
               s_d.tmr[dec.idx].pre   = `GTS_PRE_RST;
               // lower write in cascade loads upper word from holding
               if ((dec.idx == 3'h1 || dec.idx == 3'h3)
                   && s_q.tmr[dec.idx].ctrl[`GTS_CASC_BIT]) begin
                  p = (dec.idx == 3'h1) ? 0 : 1;
                  s_d.tmr[dec.idx+3'h1].count = s_q.hold[p];
               end
            end
            gts_pkg::K_PERIOD: s_d.tmr[dec.idx].period = apb_req.pwdata[15:0];
            gts_pkg::K_HOLD:   s_d.hold[dec.idx[0]]    = apb_req.pwdata[15:0];
            gts_pkg::K_FLAGS:  clr_flag                = apb_req.pwdata[4:0];
            gts_pkg::K_NONE:   clr_flag                = 5'h00;
         endcase
      end

      // set beats a same-cycle clear
      s_d.flag = (s_q.flag & ~clr_flag) | set_flag;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 5; i++) begin
            s_q.tmr[i].ctrl   <= `GTS_CTRL_RST;
            s_q.tmr[i].count  <= `GTS_COUNT_RST;
            s_q.tmr[i].period <= `GTS_PERIOD_RST;
            s_q.tmr[i].pre    <= `GTS_PRE_RST;
         end
         s_q.hold     <= '0;
         s_q.flag     <= 5'h00;
         s_q.pin_s1   <= 5'h00;
         s_q.pin_s2   <= 5'h00;
         s_q.pin_prev <= 5'h00;
         s_q.prdata   <= 32'h0000_0000;
         s_q.pready   <= 1'b0;
         s_q.pslverr  <= 1'b0;
         s_q.adc_trig <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign apb_rsp.prdata  = s_q.prdata;
   assign apb_rsp.pready  = s_q.pready;
   assign apb_rsp.pslverr = s_q.pslverr;
   assign irq_flag        = s_q.flag;
   assign adc_trig        = s_q.adc_trig;

endmodule : gts_top

// ---- shared/gts_cfg.svh ----
// constants of the general timer set: offsets, bit positions, reset values
// assumes inclusion by bare name from the package and the top module
`ifndef GTS_CFG_SVH
`define GTS_CFG_SVH

// ----------------------------------------------------------------------
// control register bit positions
// ----------------------------------------------------------------------
`define GTS_RUN_BIT      15
`define GTS_IDLE_BIT     13
`define GTS_GATE_BIT     6
`define GTS_PS_HI        5
`define GTS_PS_LO        4
`define GTS_CASC_BIT     3
`define GTS_SYNC_BIT     2
`define GTS_CS_BIT       1

// ----------------------------------------------------------------------
// writable bits per control register kind
// ----------------------------------------------------------------------
`define GTS_MASK_PRIM    16'hA076
`define GTS_MASK_LOW     16'hA07A
`define GTS_MASK_HIGH    16'hA072

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define GTS_CTRL_RST     16'h0000
`define GTS_COUNT_RST    16'h0000
`define GTS_PERIOD_RST   16'hFFFF
`define GTS_PRE_RST      8'h00

// ----------------------------------------------------------------------
// prescaler terminal counts (divide minus one)
// ----------------------------------------------------------------------
`define GTS_PS_TERM_1    8'h00
`define GTS_PS_TERM_8    8'h07
`define GTS_PS_TERM_64   8'h3F
`define GTS_PS_TERM_256  8'hFF

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define GTS_AW           8
`define GTS_OFS_P_CTRL   8'h00
`define GTS_OFS_P_COUNT  8'h04
`define GTS_OFS_P_PER    8'h08
`define GTS_OFS_A_LCTRL  8'h10
`define GTS_OFS_A_HCTRL  8'h14
`define GTS_OFS_A_LCNT   8'h18
`define GTS_OFS_A_HCNT   8'h1C
`define GTS_OFS_A_LPER   8'h20
`define GTS_OFS_A_HPER   8'h24
`define GTS_OFS_A_HOLD   8'h28
`define GTS_OFS_B_LCTRL  8'h30
`define GTS_OFS_B_HCTRL  8'h34
`define GTS_OFS_B_LCNT   8'h38
`define GTS_OFS_B_HCNT   8'h3C
`define GTS_OFS_B_LPER   8'h40
`define GTS_OFS_B_HPER   8'h44
`define GTS_OFS_B_HOLD   8'h48
`define GTS_OFS_FLAGS    8'h50

`endif

// ---- shared/gts_pkg.sv ----
// types of the general timer set
// assumes gts_cfg.svh on the include path
`include "gts_cfg.svh"

package gts_pkg;

   // ----------------------------------------------------------------------
   // bus carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [`GTS_AW-1:0] paddr;
      logic               psel;
      logic               penable;
      logic               pwrite;
      logic [31:0]        pwdata;
   } gts_apb_req_type;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } gts_apb_rsp_type;

   // ----------------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      K_NONE, K_CTRL, K_COUNT, K_PERIOD, K_HOLD, K_FLAGS
   } gts_kind_type;

   typedef struct packed {
      gts_kind_type kind;
      logic [2:0]   idx;
   } gts_dec_type;

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] count;
      logic [15:0] period;
      logic [7:0]  pre;
   } gts_timer_type;

   typedef struct packed {
      gts_timer_type [4:0] tmr;
      logic [1:0][15:0]    hold;
      logic [4:0]          flag;
      logic [4:0]          pin_s1;
      logic [4:0]          pin_s2;
      logic [4:0]          pin_prev;
      logic [31:0]         prdata;
      logic                pready;
      logic                pslverr;
      logic                adc_trig;
   } gts_state_type;

endpackage : gts_pkg

// ---- sim/gts_top_assertions.sv ----
// checker of the timer set bus answers and flag relations
// assumes binding to gts_top; one clock domain
`timescale 1ns/1ps
module gts_top_assertions (
   input wire logic                     clk,         // clock
   input wire logic                     resetn,      // reset, active low
   input wire gts_pkg::gts_apb_req_type apb_req,     // bus request
   input wire gts_pkg::gts_apb_rsp_type apb_rsp,     // bus response
   input wire logic [4:0]               ext_clk_pin, // clock and gate pins
   input wire logic                     idle_mode,   // device idle
   input wire logic                     sleep_mode,  // device sleep
   input wire logic [4:0]               irq_flag,    // sticky flags
   input wire logic                     adc_trig     // conversion trigger
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   logic clr_wr;
   assign clr_wr = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
                   && apb_req.paddr == 8'h50;

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && (a <= 8'h08 || (a >= 8'h10 && a <= 8'h28)
             || (a >= 8'h30 && a <= 8'h48) || a == 8'h50);
   endfunction : mapped

   sequence s_access;
      apb_req.psel && apb_req.penable && !apb_rsp.pready;
   endsequence
   sequence s_answer;
      apb_rsp.pready ##1 !apb_rsp.pready;
   endsequence

   a_ready_one_wait: assert property (s_access |=> s_answer)
      else $error("bus answer not one wait state");
   a_ready_in_access: assert property (apb_rsp.pready |-> apb_req.psel && apb_req.penable)
      else $error("ready outside access");
   a_err_only_bad: assert property (apb_rsp.pready |-> apb_rsp.pslverr == !mapped(apb_req.paddr))
      else $error("error flag wrong for address");
   a_err_with_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
      else $error("error without ready");
   a_rdata_narrow: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_flag_w1c: assert property (|($past(irq_flag) & ~irq_flag) |-> $past(clr_wr))
      else $error("flag dropped without clear");
   a_trig_flag: assert property (adc_trig |-> ##[0:1] irq_flag[2])
      else $error("trigger without pair a upper flag");
   a_sleep_pairs: assert property (sleep_mode [*3] |-> (irq_flag[4:1] & ~$past(irq_flag[4:1])) == 4'h0)
      else $error("pair flag rose in sleep");
endmodule : gts_top_assertions

bind gts_top gts_top_assertions chk_u (
   .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
   .ext_clk_pin(ext_clk_pin), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
   .irq_flag(irq_flag), .adc_trig(adc_trig));

// ---- sim/gts_pin_model.sv ----
// model of the external clock and gate pins
// assumes pulse is called just after a rising edge
`timescale 1ns/1ps
module gts_pin_model (
   input  wire logic       clk, // clock
   output      logic [4:0] pin  // clock and gate pins
);
   initial pin = 5'h00;

   // high for n cycles, then low two
   task automatic pulse(input int i, input int n);
      pin[i] <= 1'b1;
      repeat (n) @(posedge clk);
      pin[i] <= 1'b0;
      repeat (2) @(posedge clk);
   endtask : pulse
endmodule : gts_pin_model

// ---- sim/general_timer_set_tb_top.sv ----
// self-checking bench of the general timer set
// assumes gts_top, the pin model and the bound checker
`timescale 1ns/1ps
module general_timer_set_tb_top;
   typedef struct {
      logic [7:0]  a;
      logic        w;
      logic [15:0] d;
      logic [15:0] e;
      logic        er;
   } gts_row_type;
   logic                     clk = 1'b0;
   logic                     resetn = 1'b0;
   logic                     idle_mode = 1'b0;
   logic                     sleep_mode = 1'b0;
   gts_pkg::gts_apb_req_type apb_req = '0;
   gts_pkg::gts_apb_rsp_type apb_rsp;
   logic [4:0]               pin;
   logic [4:0]               irq_flag;
   logic                     adc_trig;
   logic [31:0]              q;
   logic [31:0]              c1;
   int err_total = 0;
   int checked = 0;
   int cyc = 0;
   int trig_cnt = 0;
   int divs [4] = '{1, 8, 64, 256};
   gts_row_type rows [12] = '{
      '{8'h00, 1'b0, 16'h0000, 16'h0000, 1'b0}, '{8'h08, 1'b0, 16'h0000, 16'hFFFF, 1'b0},
      '{8'h44, 1'b0, 16'h0000, 16'hFFFF, 1'b0}, '{8'h0C, 1'b0, 16'h0000, 16'h0000, 1'b1},
      '{8'h52, 1'b0, 16'h0000, 16'h0000, 1'b1}, '{8'h00, 1'b1, 16'hFFFF, 16'hA076, 1'b0},
      '{8'h00, 1'b1, 16'h0000, 16'h0000, 1'b0}, '{8'h10, 1'b1, 16'hFFFF, 16'hA07A, 1'b0},
      '{8'h14, 1'b1, 16'hFFFF, 16'hA072, 1'b0}, '{8'h10, 1'b1, 16'h0000, 16'h0000, 1'b0},
      '{8'h14, 1'b1, 16'h0000, 16'h0000, 1'b0}, '{8'h50, 1'b0, 16'h0000, 16'h0000, 1'b0}};

   gts_top dut_u (
      .clk(clk), .resetn(resetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .ext_clk_pin(pin), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .irq_flag(irq_flag), .adc_trig(adc_trig));
   gts_pin_model pin_u (.clk(clk), .pin(pin));

   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   always @(posedge clk) if (adc_trig === 1'b1) trig_cnt <= trig_cnt + 1;

   // ----------------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------------
   task automatic results;
      $display("errors %0d checks %0d", err_total, checked);
      if (err_total == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask : chk

   task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      apb_req.paddr <= a;
      apb_req.pwrite <= w;
      apb_req.pwdata <= {16'h0000, d};
      apb_req.psel <= 1'b1;
      @(posedge clk);
      apb_req.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (apb_rsp.pready !== 1'b1 && n < 20);
      r = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req.psel <= 1'b0;
      apb_req.penable <= 1'b0;
      @(posedge clk);
      if (n >= 20) begin
         err_total++;
         results();
      end
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] r;
      logic        e;
      xfer(a, 1'b1, d, r, e);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      logic e;
      xfer(a, 1'b0, 16'h0000, r, e);
   endtask : rd

   task automatic wait_flag(input int i, output int t);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (irq_flag[i] !== 1'b1 && n < 5000);
      t = cyc;
      if (n >= 5000) begin
         err_total++;
         results();
      end
   endtask : wait_flag

   // interval between two flags equals (period+1)*div
   task automatic meas(input logic [7:0] c, input logic [7:0] n, input logic [7:0] p,
                       input int i, input logic [15:0] cv, input logic [15:0] per,
                       input int ex);
      int t0;
      int t1;
      wr(c, 16'h0000);
      wr(p, per);
      wr(n, 16'h0000);
      wr(8'h50, 16'h001F);
      wr(c, cv);
      wait_flag(i, t0);
      wr(8'h50, 16'h001F);
      wait_flag(i, t1);
      chk(32'(t1 - t0), 32'(ex));
      wr(c, 16'h0000);
   endtask : meas

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[k]) begin
         logic e;
         xfer(rows[k].a, rows[k].w, rows[k].d, q, e);
         if (rows[k].w) xfer(rows[k].a, 1'b0, 16'h0000, q, e);
         chk(q, {16'h0000, rows[k].e});
         chk({31'h0, e}, {31'h0, rows[k].er});
      end
      for (int k = 0; k < 4; k++) meas(8'h00, 8'h04, 8'h08, 0, 16'h8000 | 16'(k << 4),
                                       16'h000F, 16 * divs[k]);
      wr(8'h44, 16'h0000);
      meas(8'h30, 8'h38, 8'h40, 4, 16'h8008, 16'h0014, 21);
      chk({31'h0, irq_flag[3]}, 32'h0);
      chk(32'(trig_cnt), 32'h0);
      meas(8'h14, 8'h1C, 8'h24, 2, 16'h8010, 16'h0003, 32);
      chk(32'(trig_cnt > 0), 32'h1);
      wr(8'h30, 16'h0008);
      wr(8'h48, 16'h0001);
      wr(8'h38, 16'h0002);
      wr(8'h48, 16'h0007);
      rd(8'h3C, q);
      chk(q, 32'h1);
      rd(8'h38, q);
      chk(q, 32'h2);
      rd(8'h48, q);
      chk(q, 32'h1);
      wr(8'h10, 16'h0000);
      wr(8'h20, 16'h0002);
      wr(8'h18, 16'h0000);
      wr(8'h50, 16'h001F);
      wr(8'h10, 16'h8002);
      repeat (2) pin_u.pulse(1, 2);
      repeat (6) @(posedge clk);
      chk({31'h0, irq_flag[1]}, 32'h0);
      pin_u.pulse(1, 2);
      repeat (6) @(posedge clk);
      chk({31'h0, irq_flag[1]}, 32'h1);
      wr(8'h10, 16'h0000);
      wr(8'h08, 16'hFFFF);
      wr(8'h04, 16'h0000);
      wr(8'h50, 16'h001F);
      wr(8'h00, 16'h8040);
      repeat (20) @(posedge clk);
      rd(8'h04, q);
      chk(q, 32'h0);
      pin_u.pulse(0, 10);
      repeat (6) @(posedge clk);
      chk({31'h0, irq_flag[0]}, 32'h1);
      rd(8'h04, q);
      chk(q, 32'hA);
      idle_mode <= 1'b1;
      wr(8'h00, 16'hA000);
      rd(8'h04, c1);
      repeat (10) @(posedge clk);
      rd(8'h04, q);
      chk(q, c1);
      wr(8'h00, 16'h8000);
      rd(8'h04, c1);
      repeat (10) @(posedge clk);
      rd(8'h04, q);
      chk(32'(q !== c1), 32'h1);
      idle_mode <= 1'b0;
      wr(8'h00, 16'h0000);
      wr(8'h04, 16'h0000);
      wr(8'h00, 16'h8002);
      wr(8'h10, 16'h8040);
      sleep_mode <= 1'b1;
      repeat (3) pin_u.pulse(0, 2);
      pin_u.pulse(1, 2);
      repeat (6) @(posedge clk);
      sleep_mode <= 1'b0;
      rd(8'h04, q);
      chk(q, 32'h3);
      chk({31'h0, irq_flag[1]}, 32'h0);
      wr(8'h00, 16'h8006);
      sleep_mode <= 1'b1;
      pin_u.pulse(0, 2);
      repeat (6) @(posedge clk);
      sleep_mode <= 1'b0;
      rd(8'h04, q);
      chk(q, 32'h3);
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      chk({27'h0, irq_flag}, 32'h0);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      rd(8'h00, q);
      chk(q, 32'h0);
      results();
   end

   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      results();
   end
endmodule : general_timer_set_tb_top
